// ---- rtl/sdpc_pkg.sv ----
package sdpc_pkg;
	// ==========================================================
	// Serial word framing
	localparam int          SDPC_WORD_W      = 24;          // Bits per programming word
	localparam logic [3:0]  SDPC_CTRL_MAIN   = 4'h3;        // Main-loop word selector
	localparam logic [3:0]  SDPC_CTRL_AUX    = 4'h5;        // Aux-loop word selector
	// ==========================================================
	// Main-loop word field positions
	localparam int          SDPC_MPD_BIT     = 23;          // Main power-down
	localparam int          SDPC_PSC_BIT     = 22;          // Prescaler select
	localparam int          SDPC_REF_HI      = 21;          // Reference divide, top
	localparam int          SDPC_REF_LO      = 16;          // Reference divide, bottom
	localparam int          SDPC_DEN_HI      = 15;          // Fraction denominator, top
	localparam int          SDPC_DEN_LO      = 4;           // Fraction denominator, bottom
	// ==========================================================
	// Aux-loop and first-word field positions
	localparam int          SDPC_APD_BIT     = 23;          // Aux power-down
	localparam int          SDPC_AUXN_HI     = 22;          // Aux divide, top
	localparam int          SDPC_AUXN_LO     = 4;           // Aux divide, bottom
	localparam int          SDPC_FBN_HI      = 23;          // Main feedback divide, top
	localparam int          SDPC_FBN_LO      = 13;          // Main feedback divide, bottom
	// ==========================================================
	// Reset values: both loops start powered down
	localparam logic        SDPC_MPD_RST     = 1'h1;
	localparam logic        SDPC_PSC_RST     = 1'h0;
	localparam logic [5:0]  SDPC_REF_RST     = 6'h01;
	localparam logic [11:0] SDPC_DEN_RST     = 12'h000;
	localparam logic        SDPC_APD_RST     = 1'h1;
	localparam logic [18:0] SDPC_AUXN_RST    = 19'h00000;
	localparam logic [10:0] SDPC_FBN_RST     = 11'h000;
	// ==========================================================
	// Divide legality limits
	localparam logic [10:0] SDPC_L16_MIN2    = 11'd49;      // Second order only
	localparam logic [10:0] SDPC_L16_MIN3    = 11'd51;      // Second or third order
	localparam logic [10:0] SDPC_L16_MIN     = 11'd55;      // Any order
	localparam logic [10:0] SDPC_L16_MAX     = 11'd2039;
	localparam logic [10:0] SDPC_L16_MAX3    = 11'd2043;
	localparam logic [10:0] SDPC_L16_MAX2    = 11'd2045;
	localparam logic [10:0] SDPC_L8_MIN2     = 11'd25;
	localparam logic [10:0] SDPC_L8_MIN3     = 11'd27;
	localparam logic [10:0] SDPC_L8_MIN      = 11'd31;
	localparam logic [10:0] SDPC_L8_MAX      = 11'd1023;
	localparam logic [18:0] SDPC_AUX_FREE    = 19'd56;      // Every value from here is legal
	localparam logic [18:0] SDPC_AUX_MIN     = 19'd24;

	// Main-loop configuration word contents
	typedef struct packed {
		logic        pd;
		logic        psc;
		logic [5:0]  ref_div;
		logic [11:0] den;
	} sdpc_main_s;

	// Aux-loop configuration word contents
	typedef struct packed {
		logic        pd;
		logic [18:0] n;
	} sdpc_aux_s;
endpackage

// ---- rtl/sdpc_top.sv ----
// Notes on behaviour
// - Large prescaler: 7/2/2 split, 55-2039 usable
// - Control 0011 word: pd, prescaler, ref, denominator
// - Reference divider accepts 1 through 63
// - Prescaler bit picks 8-modulus or 16-modulus
// - Main power-down bit powers off, tristates pump
// - Chip enable low forces main power-down
// - Auto power-up beats bit; else bit decides
// - Control 0101 word: aux pd, 19-bit divide
// - Small aux prescaler: 16/3 split, legal sets
// - Ratio equals modulus*high plus 4*middle plus low
// - Aux power-down bit powers off, tristates pump
// - Auto power-up plus first word clears aux pd
`timescale 1ns/10ps
`default_nettype none
module sdpc_top
	import sdpc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// Serial pins from the host
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        latch_strobe,
	// Chip-enable pin
	input  wire logic        chip_enable,
	// Settings from the same clock domain
	input  wire logic        auto_power_up,
	input  wire logic [2:0]  modulator_order,
	// Main-loop configuration
	output var  sdpc_main_s  main_cfg,
	output logic [10:0]      main_feedback_divide,
	output logic [6:0]       main_high_counter,
	output logic [1:0]       main_middle_counter,
	output logic [1:0]       main_low_counter,
	output logic [11:0]      main_divide_ratio,
	output logic             main_divide_legal,
	output logic             main_loop_powered,
	output logic             main_cp_tristate,
	// Aux-loop configuration
	output var  sdpc_aux_s   aux_cfg,
	output logic [15:0]      aux_high_counter,
	output logic [2:0]       aux_low_counter,
	output logic             aux_divide_legal,
	output logic             aux_loop_powered,
	output logic             aux_cp_tristate
);
	// ==========================================================
	// Pin synchronisers
	logic [2:0] sclk_sync_r;                        // Stage 3 is the edge history
	logic [1:0] data_sync_r;                        // Data sampled after two flops
	logic [2:0] latch_sync_r;                       // Stage 3 is the edge history
	logic [1:0] ce_sync_r;                          // Chip enable level
	logic       sclk_rise;                          // Serial clock rising edge
	logic       take;                               // Latch rising edge, enabled

	// Two flops before any reader; edge logic looks at stages 2 and 3 only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_sync_r  <= 3'h0;
			data_sync_r  <= 2'h0;
			latch_sync_r <= 3'h0;
			ce_sync_r    <= 2'h0;
		end
		else if (clk_en)
		begin
			sclk_sync_r  <= {sclk_sync_r[1:0], serial_clk};
			data_sync_r  <= {data_sync_r[0], serial_data};
			latch_sync_r <= {latch_sync_r[1:0], latch_strobe};
			ce_sync_r    <= {ce_sync_r[0], chip_enable};
		end
	end

	assign sclk_rise = clk_en && sclk_sync_r[1] && !sclk_sync_r[2];
	assign take      = clk_en && latch_sync_r[1] && !latch_sync_r[2];

	// ==========================================================
	// Shift register
	logic [SDPC_WORD_W-1:0] shift_r;                // Word being received

	// New bit enters at the bottom so the first bit ends on top
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			shift_r <= '0;
		else if (sclk_rise)
			shift_r <= {shift_r[SDPC_WORD_W-2:0], data_sync_r[1]};
	end

	// ==========================================================
	// Configuration registers
	sdpc_main_s  main_r;                            // Main-loop word
	sdpc_aux_s   aux_r;                             // Aux-loop word
	logic [10:0] fbn_r;                             // Divide from first word
	logic        first_word;                        // Single control bit clear

	assign first_word = (shift_r[0] == 1'b0);

	// Main word: only touched on the latch, so a half shifted word never shows
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			main_r <= '{SDPC_MPD_RST, SDPC_PSC_RST, SDPC_REF_RST, SDPC_DEN_RST};
		else if (take && shift_r[3:0] == SDPC_CTRL_MAIN)
		begin
			main_r.pd      <= shift_r[SDPC_MPD_BIT];
			main_r.psc     <= shift_r[SDPC_PSC_BIT];
			main_r.ref_div <= shift_r[SDPC_REF_HI:SDPC_REF_LO];
			main_r.den     <= shift_r[SDPC_DEN_HI:SDPC_DEN_LO];
		end
	end

	// Aux word; auto power-up clears its pd bit on a first-word write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			aux_r <= '{SDPC_APD_RST, SDPC_AUXN_RST};
		else if (take && shift_r[3:0] == SDPC_CTRL_AUX)
		begin
			aux_r.pd <= shift_r[SDPC_APD_BIT];
			aux_r.n  <= shift_r[SDPC_AUXN_HI:SDPC_AUXN_LO];
		end
		else if (take && first_word && auto_power_up)
			aux_r.pd <= 1'b0;
	end

	// Feedback divide from the first word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fbn_r <= SDPC_FBN_RST;
		else if (take && first_word)
			fbn_r <= shift_r[SDPC_FBN_HI:SDPC_FBN_LO];
	end

	// ==========================================================
	// Power control
	logic main_pwr_r;                               // Main loop running
	logic aux_pwr_r;                                // Aux loop running

	// Chip enable first, auto power-up next, power-down bit last
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			main_pwr_r <= 1'b0;
			aux_pwr_r  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!ce_sync_r[1])
				main_pwr_r <= 1'b0;
			else if (auto_power_up)
				main_pwr_r <= 1'b1;
			else
				main_pwr_r <= !main_r.pd;
			aux_pwr_r <= ce_sync_r[1] && !aux_r.pd;
		end
	end

	assign main_loop_powered = main_pwr_r;
	assign main_cp_tristate  = !main_pwr_r;
	assign aux_loop_powered  = aux_pwr_r;
	assign aux_cp_tristate   = !aux_pwr_r;

	// ==========================================================
	// Counter split and legality
	function automatic logic main_legal(input logic [10:0] n, input logic psc, input logic [2:0] ord);
		logic o2;
		logic o3;
		o2 = (ord == 3'd2);
		o3 = (ord == 3'd2) || (ord == 3'd3);
		if (psc)
			main_legal = (n >= SDPC_L16_MIN && n <= SDPC_L16_MAX)
				|| (o3 && n >= SDPC_L16_MIN3 && n <= SDPC_L16_MAX3)
				|| (o2 && n >= SDPC_L16_MIN2 && n <= SDPC_L16_MAX2);
		else
			main_legal = (n >= SDPC_L8_MIN && n <= SDPC_L8_MAX)
				|| (o3 && n >= SDPC_L8_MIN3 && n <= SDPC_L8_MAX)
				|| (o2 && n >= SDPC_L8_MIN2 && n <= SDPC_L8_MAX);
	endfunction

	// Below the free range the low counter may not exceed the high counter
	function automatic logic aux_legal(input logic [18:0] n);
		aux_legal = (n >= SDPC_AUX_FREE)
			|| (n >= SDPC_AUX_MIN && n[2:0] <= n[5:3]);
	endfunction

	// Small prescaler has one spare middle bit, so the high counter shifts down
	always_comb
	begin
		if (main_r.psc)
		begin
			main_high_counter   = fbn_r[10:4];
			main_middle_counter = fbn_r[3:2];
		end
		else
		begin
			main_high_counter   = fbn_r[9:3];
			main_middle_counter = {1'b0, fbn_r[2]};
		end
	end

	assign main_low_counter     = fbn_r[1:0];
	assign main_divide_ratio    = 12'((main_r.psc ? 12'h010 : 12'h008) * {5'h00, main_high_counter}
		+ {8'h00, main_middle_counter, 2'h0} + {10'h000, main_low_counter});
	assign main_divide_legal    = main_legal(fbn_r, main_r.psc, modulator_order);
	assign main_feedback_divide = fbn_r;
	assign main_cfg             = main_r;
	assign aux_cfg              = aux_r;
	assign aux_high_counter     = aux_r.n[18:3];
	assign aux_low_counter      = aux_r.n[2:0];
	assign aux_divide_legal     = aux_legal(aux_r.n);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	main_word_load_a: assert property (take && shift_r[3:0] == SDPC_CTRL_MAIN |=> main_r.ref_div == $past(shift_r[21:16]) && main_r.pd == $past(shift_r[23])) else $error("main word not loaded");
	aux_word_load_a: assert property (take && shift_r[3:0] == SDPC_CTRL_AUX |=> aux_r.n == $past(shift_r[22:4])) else $error("aux word not loaded");
	config_hold_a: assert property (!take |=> $stable(main_r) && $stable(aux_r) && $stable(fbn_r)) else $error("config changed without latch");
	shift_msb_a: assert property (sclk_rise |=> shift_r[0] == $past(data_sync_r[1]) && shift_r[23:1] == $past(shift_r[22:0])) else $error("bad shift");
	ce_priority_a: assert property (clk_en && !ce_sync_r[1] |=> !main_loop_powered && main_cp_tristate) else $error("chip enable ignored");
	auto_power_up_power_a: assert property (clk_en && ce_sync_r[1] && auto_power_up |=> main_loop_powered) else $error("auto power-up ignored");
	pd_bit_a: assert property (clk_en && ce_sync_r[1] && !auto_power_up |=> main_loop_powered == !$past(main_r.pd)) else $error("power-down bit ignored");
	aux_clear_a: assert property (take && first_word && auto_power_up |=> !aux_r.pd
		and (clk_en && ce_sync_r[1] |=> aux_loop_powered)) else $error("aux pd not cleared");
	aux_pd_a: assert property (clk_en && aux_r.pd |=> !aux_loop_powered && aux_cp_tristate)
		else $error("aux power-down ignored");
	ratio_match_a: assert property (main_r.psc || !fbn_r[10] |-> main_divide_ratio == {1'b0, fbn_r})
		else $error("ratio mismatch");
	main_range_a: assert property (main_r.psc && fbn_r >= 11'd55 && fbn_r <= 11'd2039 |-> main_divide_legal) else $error("legal main value flagged");
	aux_range_a: assert property ((aux_r.n <= 19'd23 |-> !aux_divide_legal) and (aux_r.n == 19'd28 |-> !aux_divide_legal)) else $error("aux legality wrong");

	main_load_c: cover property (take && shift_r[3:0] == SDPC_CTRL_MAIN);
	aux_clear_c: cover property (take && first_word && auto_power_up && aux_r.pd);
	ce_drop_c: cover property (main_loop_powered ##1 !main_loop_powered);
endmodule
`default_nettype wire

// ---- tb/sdpc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host-side serial writer
module sdpc_host_model
	import sdpc_pkg::*;
(
	// Serial pins toward the device
	output var logic serial_clk,
	output var logic serial_data,
	output var logic latch_strobe
);
	// Link clock and strobe stand low between frames
	initial
	begin
		serial_clk   = 1'b0;
		serial_data  = 1'b0;
		latch_strobe = 1'b0;
	end
	// One word, then a latch pulse; odd offset keeps the link out of phase
	task automatic send(input logic [SDPC_WORD_W-1:0] w);
		#1.7;
		for (int i = SDPC_WORD_W - 1; i >= 0; i--)
		begin
			serial_data = w[i];
			#32 serial_clk = 1'b1;
			#32 serial_clk = 1'b0;
		end
		// Released data line must not show a stale bit
		serial_data = ~w[0];
		#32 latch_strobe = 1'b1;
		#64 latch_strobe = 1'b0;
		#32;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the divider and power words
module tb;
	import sdpc_pkg::*;
	// Expected outputs after one step
	typedef struct packed {
		sdpc_main_s  m;
		sdpc_aux_s   a;
		logic [10:0] n;
		logic [6:0]  hi;
		logic [11:0] rat;
		logic        ml, al, mp, ap;
	} sdpc_note_s;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, apu = 1'b0, cke = 1'b1;
	logic [2:0]  ord = 3'h3;
	logic        sck, sdat, lat, mleg_o, aleg_o, mpw, mtri, apw, atri;
	sdpc_main_s  main_cfg, em;
	sdpc_aux_s   aux_cfg, ea;
	logic [10:0] fbn, en;
	logic [6:0]  mhi;
	logic [11:0] rat;
	sdpc_note_s  q[$];
	int          n_errors = 0, total_checks = 0, cyc = 0;
	event        smp;
	// ==========================================
	// Clock, far side, device
	always #2 clk = ~clk;
	sdpc_host_model i_host (.serial_clk(sck), .serial_data(sdat), .latch_strobe(lat));
	sdpc_top i_dut (.clk(clk), .rst(rst), .clk_en(cke), .serial_clk(sck), .serial_data(sdat),
		.latch_strobe(lat), .chip_enable(ce), .auto_power_up(apu), .modulator_order(ord),
		.main_cfg(main_cfg), .main_feedback_divide(fbn), .main_high_counter(mhi),
		.main_middle_counter(), .main_low_counter(), .main_divide_ratio(rat),
		.main_divide_legal(mleg_o), .main_loop_powered(mpw), .main_cp_tristate(mtri),
		.aux_cfg(aux_cfg), .aux_high_counter(), .aux_low_counter(), .aux_divide_legal(aleg_o),
		.aux_loop_powered(apw), .aux_cp_tristate(atri));
	// ==========================================
	// Expectation helpers
	function automatic logic mleg(input logic p, input logic [10:0] n, input logic [2:0] o);
		int lo, hi, x;
		lo = p ? 55 : 31;
		hi = p ? 2039 : 1023;
		x = p ? 4 : 0;
		return (n >= lo && n <= hi) || (o <= 3 && n >= lo - 4 && n <= hi + x)
			|| (o == 2 && n >= lo - 6 && n <= hi + x + x / 2);
	endfunction
	function automatic logic aleg(input logic [18:0] n);
		return n >= 56 || n inside {[24:27], [32:36], [40:45], [48:54]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Note the expected state, let the sync chain settle, then sample
	task automatic note();
		sdpc_note_s e;
		@(negedge clk);
		e = '{em, ea, en, em.psc ? en[10:4] : en[9:3], em.psc ? {1'b0, en} : {2'b00, en[9:0]},
			mleg(em.psc, en, ord), aleg(ea.n), ce & (apu | ~em.pd), ce & ~ea.pd};
		q.push_back(e);
		repeat (8) @(negedge clk);
		-> smp;
		@(negedge clk);
	endtask
	task automatic set_in(input logic c, input logic a, input logic [2:0] o);
		@(negedge clk);
		ce = c;
		apu = a;
		ord = o;
	endtask
	task automatic wr_main(input logic pd, input logic p, input logic [5:0] r, input logic [11:0] d);
		em = '{pd, p, r, d};
		i_host.send({em, SDPC_CTRL_MAIN});
	endtask
	task automatic wr_aux(input logic pd, input logic [18:0] n);
		ea = '{pd, n};
		i_host.send({ea, SDPC_CTRL_AUX});
	endtask
	// First word also clears aux power-down under auto power-up
	task automatic wr_first(input logic [10:0] n);
		en = n;
		if (apu)
			ea.pd = 1'b0;
		i_host.send({n, 12'($urandom), 1'b0});
	endtask
	// ==========================================
	// Output watcher: oldest note against what the device shows
	always @(smp)
	begin
		sdpc_note_s e;
		e = q.pop_front();
		chk(main_cfg, e.m);
		chk(aux_cfg, e.a);
		chk(fbn, e.n);
		chk(mhi, e.hi);
		chk(rat, e.rat);
		chk(mleg_o, e.ml);
		chk(aleg_o, e.al);
		chk({mpw, mtri}, {e.mp, ~e.mp});
		chk({apw, atri}, {e.ap, ~e.ap});
	end
	// Hang guard: roughly twice the expected run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			end_sim();
		end
	end
	// ==========================================
	// Main sequence
	initial
	begin
		static logic [18:0] av[10] = '{19'h17, 19'h18, 19'h1B, 19'h1C, 19'h20, 19'h24, 19'h25, 19'h37,
			19'h38, 19'h3FFFF};
		static logic [10:0] nv[15] = '{11'h018, 11'h019, 11'h01B, 11'h01E, 11'h01F, 11'h030, 11'h031,
			11'h033, 11'h037, 11'h3FF, 11'h400, 11'h7F7, 11'h7F8, 11'h7FC, 11'h7FE};
		void'($urandom(32'hD72EB1BC));
		em = '{SDPC_MPD_RST, SDPC_PSC_RST, SDPC_REF_RST, SDPC_DEN_RST};
		ea = '{SDPC_APD_RST, SDPC_AUXN_RST};
		en = SDPC_FBN_RST;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		note();
		$display("test reset done");
		// Both prescalers, both power states, reference extremes
		for (int k = 0; k < 4; k++)
		begin
			wr_main(k[0], k[1], k[0] ? 6'h3F : 6'h01, 12'($urandom));
			note();
		end
		$display("test main word done");
		// Aux divide around the legality edges at 24, 28, 32, 37 and 56
		foreach (av[i])
		begin
			wr_aux(i[0], av[i]);
			note();
		end
		wr_aux(1'b0, 19'($urandom));
		note();
		$display("test aux word done");
		// Main divide edges for each prescaler and modulator orders 2 to 4
		for (int p = 0; p < 2; p++)
		begin
			wr_main(1'b0, p[0], 6'h05, 12'($urandom));
			foreach (nv[i])
			begin
				wr_first(nv[i]);
				for (int o = 2; o <= 4; o++)
				begin
					set_in(1'b1, 1'b0, o[2:0]);
					note();
				end
			end
		end
		$display("test divide legality done");
		// Chip enable, auto power-up and power bit in every mix
		for (int k = 0; k < 8; k++)
		begin
			wr_main(k[2], 1'b1, 6'h02, 12'h000);
			set_in(k[0], k[1], 3'h3);
			note();
		end
		$display("test power priority done");
		set_in(1'b1, 1'b1, 3'h3);
		wr_aux(1'b1, 19'h00040);
		note();
		wr_first(11'h100);
		note();
		$display("test auto power-up done");
		// Frozen clock enable: a whole word must leave no trace
		@(negedge clk);
		cke = 1'b0;
		i_host.send({~em.pd, ~em.psc, em.ref_div, em.den, SDPC_CTRL_MAIN});
		@(negedge clk);
		cke = 1'b1;
		note();
		$display("test clock enable done");
		// Unknown selectors must leave everything untouched
		i_host.send({20'($urandom), 4'h7});
		note();
		i_host.send({20'($urandom), 4'hB});
		note();
		$display("test ignored words done");
		end_sim();
	end
endmodule
`default_nettype wire
